// file: hdl/tx_align_pkg.sv
// Constants for one transmit parallel-input channel with phase-align buffer.
// Assumes a single 125 MHz system clock; all pins are asynchronous to it.
package tx_align_pkg;
    // ==========================================================
    // Widths and buffer shape
    localparam int CHAR_WIDTH    = 10;
    localparam int CFG_ADDR_W    = 4;
    localparam int CFG_DATA_W    = 5;
    localparam int BUF_DEPTH     = 4;
    localparam int BUF_PTR_W     = 2;
    localparam logic [2:0] BUF_CENTER = 3'h2;
    localparam int DATA_DELAY    = 4;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS    = 8;
    localparam int REF_LOSS_TIME_NS = 1000;
    localparam int REF_LOSS_CYCLES  = (REF_LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] REF_LOSS_COUNT = 8'(REF_LOSS_CYCLES);
    localparam int BIST_LENGTH   = 511;
    localparam logic [8:0] BIST_LAST = 9'(BIST_LENGTH - 1);
    // ==========================================================
    // Configuration latch map
    localparam logic [3:0] CFG_ADDR_CLOCKING = 4'h0;
    localparam logic [3:0] CFG_ADDR_OUTPUT   = 4'h1;
    localparam int CFG_BIT_CLK_SEL   = 0;
    localparam int CFG_BIT_BUF_RST   = 1;
    localparam int CFG_BIT_BIST_N    = 2;
    localparam int CFG_BIT_RATE      = 3;
    localparam int CFG_BIT_HALF_RATE = 4;
    localparam int CFG_BIT_OE1       = 0;
    localparam int CFG_BIT_OE2       = 1;
    localparam logic [4:0] CFG_CLOCKING_RESET = 5'h07;
    localparam logic [4:0] CFG_OUTPUT_RESET   = 5'h00;
    // ==========================================================
    // APB map and event bits
    localparam logic [11:0] APB_STATUS = 12'h000;
    localparam logic [11:0] APB_MASK   = 12'h004;
    localparam logic [11:0] APB_STATE  = 12'h008;
    localparam int EVENT_W      = 4;
    localparam int EV_BUF_FAULT = 0;
    localparam int EV_BIST_PASS = 1;
    localparam int EV_PLL_DOWN  = 2;
    localparam int EV_REF_LOSS  = 3;
endpackage

// file: hdl/phase_align_buffer.sv
// Small elastic buffer between capture ticks and character ticks.
// Assumes both tick streams are one-cycle enables on the same clock.
`timescale 1ns/100ps
`default_nettype none
module phase_align_buffer (
    input  wire logic                                clk,
    input  wire logic                                srst,
    input  wire logic                                recenter,
    input  wire logic                                wr_en,
    input  wire logic [tx_align_pkg::CHAR_WIDTH-1:0] wr_data,
    input  wire logic                                rd_en,
    output logic      [tx_align_pkg::CHAR_WIDTH-1:0] rd_data,
    output logic                                     fault
);
    // ==========================================================
    // Storage and pointers
    logic [tx_align_pkg::CHAR_WIDTH-1:0] mem [tx_align_pkg::BUF_DEPTH];
    logic [tx_align_pkg::BUF_PTR_W-1:0]  wr_ptr;
    logic [tx_align_pkg::BUF_PTR_W-1:0]  rd_ptr;
    logic [2:0]                          fill;
    wire  full  = (fill == 3'(tx_align_pkg::BUF_DEPTH));
    wire  empty = (fill == 3'h0);
    wire  do_wr = wr_en & ~full;
    wire  do_rd = rd_en & ~empty;
    wire  [2:0] next_fill = fill + 3'(do_wr) - 3'(do_rd);

    // Half the depth on each side gives a two-character drift margin each way
    always_ff @(posedge clk) begin
        if (srst || recenter) begin
            wr_ptr <= rd_ptr + 2'(tx_align_pkg::BUF_CENTER);
            fill   <= tx_align_pkg::BUF_CENTER;
            fault  <= 1'b0;
        end else begin
            wr_ptr <= wr_ptr + 2'(do_wr);
            fill   <= next_fill;
            fault  <= (wr_en & full) | (rd_en & empty);
        end
    end

    // Read side keeps its pointer through re-centering
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_ptr  <= '0;
            rd_data <= '0;
        end else if (do_rd) begin
            rd_ptr  <= rd_ptr + 2'h1;
            rd_data <= mem[rd_ptr];
        end
    end

    // Storage carries no reset
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= wr_data;
        end
    end

    // ==========================================================
    // Checks
    property p_recenter_fill;
        @(posedge clk) disable iff (srst) recenter |=> (fill == tx_align_pkg::BUF_CENTER);
    endproperty
    a_recenter_fill: assert property (p_recenter_fill) else $error("fill not centered");
    property p_overflow;
        @(posedge clk) disable iff (srst) (wr_en && full && !recenter) |=> fault;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not flagged");
    property p_underflow;
        @(posedge clk) disable iff (srst) (rd_en && empty && !recenter) |=> fault;
    endproperty
    a_underflow: assert property (p_underflow) else $error("underflow not flagged");
endmodule // phase_align_buffer
`default_nettype wire

// file: hdl/tx_parallel_input_phase_align.sv
// One transmit parallel-input channel: capture, phase alignment, error pin.
// Assumes every pin is asynchronous to clk and clocks run well below clk/4.
`timescale 1ns/100ps
`default_nettype none
module tx_parallel_input_phase_align (
    input  wire logic                                clk,
    input  wire logic                                srst,
    input  wire logic [tx_align_pkg::CHAR_WIDTH-1:0] tx_char_in,
    input  wire logic                                host_char_clock,
    input  wire logic                                channel_ref_clock,
    input  wire logic                                config_write_strobe,
    input  wire logic [tx_align_pkg::CFG_ADDR_W-1:0] config_addr,
    input  wire logic [tx_align_pkg::CFG_DATA_W-1:0] config_data,
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [11:0]                         paddr,
    input  wire logic [31:0]                         pwdata,
    output logic      [31:0]                         prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    output logic                                     irq,
    output logic                                     tx_path_error,
    output logic                                     tx_clock_out,
    output logic      [tx_align_pkg::CHAR_WIDTH-1:0] tx_char_out,
    output logic                                     tx_char_valid
);
    // ==========================================================
    // Pin synchronisers
    logic [2:0] host_sync;
    logic [2:0] ref_sync;
    logic [2:0] strobe_sync;
    logic [tx_align_pkg::CHAR_WIDTH-1:0] data_pipe [tx_align_pkg::DATA_DELAY];
    logic [tx_align_pkg::CFG_ADDR_W-1:0] addr_s1, addr_s2;
    logic [tx_align_pkg::CFG_DATA_W-1:0] cdata_s1, cdata_s2;

    // Two stages before use; third stage for edge finding and the x1 transmit clock
    always_ff @(posedge clk) begin
        host_sync   <= {host_sync[1:0], host_char_clock};
        ref_sync    <= {ref_sync[1:0], channel_ref_clock};
        strobe_sync <= {strobe_sync[1:0], config_write_strobe};
        addr_s1     <= config_addr;
        addr_s2     <= addr_s1;
        cdata_s1    <= config_data;
        cdata_s2    <= cdata_s1;
    end

    // Data delayed past the clock so the pre-edge value is taken
    genvar gi;
    generate
        for (gi = 0; gi < tx_align_pkg::DATA_DELAY; gi++) begin : g_data
            always_ff @(posedge clk) begin
                data_pipe[gi] <= (gi == 0) ? tx_char_in : data_pipe[(gi == 0) ? 0 : gi - 1];
            end
        end
    endgenerate

    wire host_rise = host_sync[1] & ~host_sync[2];
    wire ref_rise  = ref_sync[1] & ~ref_sync[2];
    wire ref_fall  = ~ref_sync[1] & ref_sync[2];
    wire ref_edge  = ref_rise | ref_fall;
    wire cfg_load  = strobe_sync[1] & ~strobe_sync[2];

    // ==========================================================
    // Configuration latches
    logic [4:0] cfg_clocking;
    logic [4:0] cfg_output;
    logic       recenter;
    wire  sel_ref    = cfg_clocking[tx_align_pkg::CFG_BIT_CLK_SEL];
    wire  bist_n     = cfg_clocking[tx_align_pkg::CFG_BIT_BIST_N];
    wire  rate_x2    = cfg_clocking[tx_align_pkg::CFG_BIT_RATE];
    wire  half_rate  = cfg_clocking[tx_align_pkg::CFG_BIT_HALF_RATE];
    wire  pll_down   = ~cfg_output[tx_align_pkg::CFG_BIT_OE1]
                     & ~cfg_output[tx_align_pkg::CFG_BIT_OE2];
    wire  hit_clk    = cfg_load & (addr_s2 == tx_align_pkg::CFG_ADDR_CLOCKING);
    wire  hit_out    = cfg_load & (addr_s2 == tx_align_pkg::CFG_ADDR_OUTPUT);

    // Strobe edge loads the addressed latch; a 0 to buffer reset re-centers
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_clocking <= tx_align_pkg::CFG_CLOCKING_RESET;
            cfg_output   <= tx_align_pkg::CFG_OUTPUT_RESET;
            recenter     <= 1'b1;
        end else begin
            if (hit_clk) cfg_clocking <= cdata_s2;
            if (hit_out) cfg_output <= cdata_s2;
            recenter <= hit_clk & ~cdata_s2[tx_align_pkg::CFG_BIT_BUF_RST];
        end
    end

    // ==========================================================
    // Capture clock choice
    wire ref_capture = half_rate ? ref_edge : ref_rise;
    wire capture_tick = sel_ref ? ref_capture : host_rise;

    // ==========================================================
    // Transmit clock output and character tick
    logic [7:0] ref_age;
    logic [7:0] ref_half_len;
    logic       ref_absent;
    wire  mid_toggle = (ref_age == {1'b0, ref_half_len[7:1]}) & (ref_half_len != 8'h0);
    wire  next_clock_out = rate_x2 ? (tx_clock_out ^ (ref_edge | mid_toggle)) : ref_sync[2];
    wire  char_tick = next_clock_out & ~tx_clock_out & ~pll_down & ~ref_absent;

    // Age since last reference edge gives both half-period and loss check
    always_ff @(posedge clk) begin
        if (srst) begin
            ref_age      <= '0;
            ref_half_len <= '0;
            ref_absent   <= 1'b1;
            tx_clock_out <= 1'b0;
        end else begin
            if (ref_edge) begin
                ref_age      <= '0;
                ref_half_len <= ref_age;
            end else if (ref_age != 8'hff) begin
                ref_age <= ref_age + 8'h1;
            end
            ref_absent   <= ~ref_edge & (ref_age >= tx_align_pkg::REF_LOSS_COUNT);
            tx_clock_out <= next_clock_out;
        end
    end

    // ==========================================================
    // Phase-align buffer
    logic buf_fault;
    logic buf_err;
    logic buf_err_ref;

    phase_align_buffer u_buffer (
        .clk      (clk),
        .srst     (srst),
        .recenter (recenter),
        .wr_en    (capture_tick),
        .wr_data  (data_pipe[tx_align_pkg::DATA_DELAY-1]),
        .rd_en    (char_tick),
        .rd_data  (tx_char_out),
        .fault    (buf_fault)
    );

    // Sticky error; a fault in the re-center cycle still sets it
    always_ff @(posedge clk) begin
        if (srst) begin
            buf_err       <= 1'b0;
            buf_err_ref   <= 1'b0;
            tx_char_valid <= 1'b0;
        end else begin
            buf_err       <= buf_fault | (buf_err & ~recenter);
            tx_char_valid <= char_tick;
            if (ref_rise) buf_err_ref <= buf_err;
        end
    end

    // ==========================================================
    // Self-test progress counter
    logic [8:0] bist_count;
    logic       bist_pulse;
    wire  bist_wrap = char_tick & ~bist_n & (bist_count == tx_align_pkg::BIST_LAST);

    // Pulse spans one character period: set at wrap, dropped next tick
    always_ff @(posedge clk) begin
        if (srst || bist_n) begin
            bist_count <= '0;
            bist_pulse <= 1'b0;
        end else if (char_tick) begin
            bist_count <= bist_wrap ? 9'h0 : bist_count + 9'h1;
            bist_pulse <= bist_wrap;
        end
    end

    // ==========================================================
    // Error output
    wire status_err = bist_n ? buf_err_ref : bist_pulse;
    wire next_error = pll_down | ref_absent | status_err;

    always_ff @(posedge clk) begin
        if (srst) begin
            tx_path_error <= 1'b1;
        end else begin
            tx_path_error <= next_error;
        end
    end

    // ==========================================================
    // Event capture and interrupt
    logic [tx_align_pkg::EVENT_W-1:0] ev_status;
    logic [tx_align_pkg::EVENT_W-1:0] ev_mask;
    logic                             pll_down_d;
    logic                             ref_absent_d;
    wire  [tx_align_pkg::EVENT_W-1:0] ev_set = {ref_absent & ~ref_absent_d,
                                                pll_down & ~pll_down_d,
                                                bist_wrap, buf_fault};
    wire  apb_access  = psel & penable & ~pready;
    wire  apb_wr      = psel & penable & pready & pwrite; // Lands on the completing edge
    wire  sel_status  = (paddr == tx_align_pkg::APB_STATUS);
    wire  sel_mask    = (paddr == tx_align_pkg::APB_MASK);
    wire  sel_state   = (paddr == tx_align_pkg::APB_STATE);
    wire  unmapped    = ~(sel_status | sel_mask | sel_state);
    wire  [tx_align_pkg::EVENT_W-1:0] w1c =
        (apb_wr & sel_status) ? pwdata[tx_align_pkg::EVENT_W-1:0] : '0;
    wire  [tx_align_pkg::EVENT_W-1:0] next_status = ev_set | (ev_status & ~w1c);
    // Mask as it stands after this edge keeps irq in step with a mask write
    wire  [tx_align_pkg::EVENT_W-1:0] next_mask =
        (apb_wr & sel_mask) ? pwdata[tx_align_pkg::EVENT_W-1:0] : ev_mask;
    wire  [31:0] state_word = {20'h0, 3'(u_buffer.fill), tx_path_error,
                               cfg_output[1:0], 1'b0, cfg_clocking};
    wire  [31:0] read_word  = sel_status ? {28'h0, ev_status}
                            : sel_mask   ? {28'h0, ev_mask}
                            : sel_state  ? state_word : 32'h0;

    // Set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            ev_status    <= '0;
            ev_mask      <= '0;
            pll_down_d   <= 1'b1;
            ref_absent_d <= 1'b1;
            irq          <= 1'b0;
        end else begin
            ev_status    <= next_status;
            pll_down_d   <= pll_down;
            ref_absent_d <= ref_absent;
            ev_mask      <= next_mask;
            irq          <= |(next_status & next_mask);
        end
    end

    // One wait state: answer registered on the first access cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= apb_access;
            pslverr <= apb_access & unmapped;
            prdata  <= (apb_access && !pwrite) ? read_word : 32'h0;
        end
    end

    // ==========================================================
    // Checks
    // Causes of the error pin
    property p_pll_error;
        @(posedge clk) disable iff (srst) pll_down |=> tx_path_error;
    endproperty
    a_pll_error: assert property (p_pll_error) else $error("pll down without error");

    property p_ref_loss;
        @(posedge clk) disable iff (srst)
            (!ref_edge && ref_age >= tx_align_pkg::REF_LOSS_COUNT) |=> ##1 tx_path_error;
    endproperty
    a_ref_loss: assert property (p_ref_loss) else $error("ref loss without error");

    property p_error_low;
        @(posedge clk) disable iff (srst)
            !tx_path_error |-> (!$past(pll_down) && !$past(ref_absent));
    endproperty
    a_error_low: assert property (p_error_low) else $error("error low while down");

    // Buffer state and its clock domain
    property p_buf_sticky;
        @(posedge clk) disable iff (srst) (buf_err && !recenter) |=> buf_err;
    endproperty
    a_buf_sticky: assert property (p_buf_sticky) else $error("buffer error dropped");

    property p_buffer_recenter;
        @(posedge clk) disable iff (srst)
            (hit_clk && !cdata_s2[tx_align_pkg::CFG_BIT_BUF_RST]) |=> ##1
                (u_buffer.fill == tx_align_pkg::BUF_CENTER);
    endproperty
    a_buffer_recenter: assert property (p_buffer_recenter) else $error("no re-center");

    property p_ref_domain;
        @(posedge clk) disable iff (srst) !ref_rise |=> $stable(buf_err_ref);
    endproperty
    a_ref_domain: assert property (p_ref_domain) else $error("error moved off ref edge");

    // Capture clock selection
    property p_capture_host;
        @(posedge clk) disable iff (srst) (!sel_ref && capture_tick) |-> host_rise;
    endproperty
    a_capture_host: assert property (p_capture_host) else $error("host capture misfired");

    property p_capture_ref;
        @(posedge clk) disable iff (srst) (sel_ref && !half_rate && capture_tick) |-> ref_rise;
    endproperty
    a_capture_ref: assert property (p_capture_ref) else $error("ref capture misfired");

    property p_half_rate;
        @(posedge clk) disable iff (srst) (sel_ref && half_rate && ref_edge) |-> capture_tick;
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("half-rate edge missed");

    // Transmit clock and self-test
    property p_rate_x1;
        @(posedge clk) disable iff (srst) !rate_x2 |=> (tx_clock_out == $past(ref_sync[2]));
    endproperty
    a_rate_x1: assert property (p_rate_x1) else $error("clock out off reference");

    property p_bist_pulse;
        @(posedge clk) disable iff (srst || bist_n)
            $rose(bist_pulse) |-> $past(bist_count) == tx_align_pkg::BIST_LAST;
    endproperty
    a_bist_pulse: assert property (p_bist_pulse) else $error("bist pulse off count");

    property p_bist_out;
        @(posedge clk) disable iff (srst)
            (!bist_n && !pll_down && !ref_absent) |=> (tx_path_error == $past(bist_pulse));
    endproperty
    a_bist_out: assert property (p_bist_out) else $error("bist progress not shown");

    // Register bus and interrupt
    property p_irq;
        @(posedge clk) disable iff (srst) (|(ev_status & ev_mask)) |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    // Irq falls with the last unmasked bit
    property p_irq_low;
        @(posedge clk) disable iff (srst) !(|(ev_status & ev_mask)) |-> !irq;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("irq stuck high");

    property p_apb_answer;
        @(posedge clk) disable iff (srst) (psel && penable && !pready) |=> pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");

    property p_ready_pulse;
        @(posedge clk) disable iff (srst) pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

    // Main scenarios reached
    c_bist_pass: cover property (@(posedge clk) disable iff (srst) $rose(bist_pulse));
    c_buf_fault: cover property (@(posedge clk) disable iff (srst) buf_fault);
    c_error_clear: cover property (@(posedge clk) disable iff (srst) $fell(tx_path_error));
    c_irq: cover property (@(posedge clk) disable iff (srst) $rose(irq));
    c_ref_loss: cover property (@(posedge clk) disable iff (srst) $rose(ref_absent));
endmodule // tx_parallel_input_phase_align
`default_nettype wire

// file: dv/host_char_source.sv
// Host logic model: drives the character clock and a counting character stream.
// Assumes the bench supplies the channel reference clock and a start/stop level.
`timescale 1ns/100ps
`default_nettype none
module host_char_source (
    input  wire logic                                channel_ref_clock,
    input  wire logic                                run,
    input  wire logic [5:0]                          phase_ns,
    input  wire logic [tx_align_pkg::CHAR_WIDTH-1:0] first_char,
    output logic                                     host_char_clock,
    output logic      [tx_align_pkg::CHAR_WIDTH-1:0] tx_char_in
);
    // ==========================================================
    // Clock and data
    // Clock stands low while stopped; same period as the reference, fixed offset
    initial begin
        host_char_clock = 1'b0;
        tx_char_in      = '0;
    end
    always begin
        wait (run);
        tx_char_in = first_char;
        @(posedge channel_ref_clock);
        #(phase_ns);
        while (run) begin
            host_char_clock = 1'b1;
            #80;
            host_char_clock = 1'b0;
            tx_char_in      = tx_char_in + 1'b1; // Moves on fall, clear of capture
            #80;
        end
    end
endmodule // host_char_source
`default_nettype wire

// file: dv/tx_parallel_input_phase_align_tb.sv
// Self-checking bench for one transmit parallel-input channel.
// Assumes host_char_source as far side and a 160 ns reference clock.
`timescale 1ns/100ps
`default_nettype none
module tx_parallel_input_phase_align_tb;
    localparam int CHAR_CYC = 20;
    logic        clk = 1'b0;
    logic        srst, ref_clk, ref_run, host_run, seq_on, have_prev;
    logic        strobe, psel, penable, pwrite, pready, pslverr, irq, err, clk_out, valid, er;
    logic [3:0]  cfg_addr;
    logic [4:0]  cfg_data;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, rnd;
    logic [5:0]  phase_ns;
    logic [9:0]  first_char, char_in, char_out, prev_char;
    logic        host_clk;
    int          miscompares, checks_done, cycles, w, p, n;

    // ==========================================================
    // Clocks, partner and design
    always #4 clk = ~clk;
    always #80 if (ref_run) ref_clk = ~ref_clk;
    host_char_source host (.channel_ref_clock(ref_clk), .run(host_run), .phase_ns(phase_ns),
        .first_char(first_char), .host_char_clock(host_clk), .tx_char_in(char_in));
    tx_parallel_input_phase_align dut (.clk(clk), .srst(srst), .tx_char_in(char_in),
        .host_char_clock(host_clk), .channel_ref_clock(ref_clk),
        .config_write_strobe(strobe), .config_addr(cfg_addr), .config_data(cfg_data),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .tx_path_error(err), .tx_clock_out(clk_out), .tx_char_out(char_out),
        .tx_char_valid(valid));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic in_tol(input int v, input int c, input int t);
        return (v >= c - t) && (v <= c + t);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin @(posedge clk); end while (pready !== 1'b1); // Hang guard ends a lost answer
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // Latch writes keep address and data steady well around the strobe
    task automatic cfg(input logic [3:0] a, input logic [4:0] d);
        @(posedge clk);
        cfg_addr <= a; cfg_data <= d;
        repeat (4) @(posedge clk);
        strobe <= 1'b1;
        repeat (8) @(posedge clk);
        strobe <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic wait_err(input logic v, input int lim);
        int k;
        k = 0;
        while (err !== v && k < lim) begin @(posedge clk); k++; end
    endtask
    task automatic recenter(input logic [4:0] base);
        repeat (2) begin // Second pass clears a fault that lands on the first
            cfg(4'h0, base & 5'h1d);
            cfg(4'h0, base);
        end
        wait_err(1'b0, 400);
    endtask
    task automatic count_rises(output int c);
        logic last;
        last = clk_out;
        c = 0;
        repeat (400) begin
            @(posedge clk);
            if (clk_out === 1'b1 && last !== 1'b1) c++;
            last = clk_out;
        end
    endtask
    task automatic pulse_timing(output int pw, output int pp);
        wait_err(1'b1, 11000);
        pw = 0;
        while (err === 1'b1 && pw < 100) begin @(posedge clk); pw++; end
        pp = pw;
        while (err !== 1'b1 && pp < 11000) begin @(posedge clk); pp++; end
    endtask
    task automatic run_seq();
        repeat (3 * CHAR_CYC) @(posedge clk); // Stale slots after re-centering drain first
        have_prev = 1'b0;
        seq_on = 1'b1;
        repeat (40 * CHAR_CYC) @(posedge clk);
        seq_on = 1'b0;
    endtask
    task automatic report_and_stop;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================================
    // Monitors
    // No lost or repeated character while the stream is coherent
    always @(posedge clk) begin
        if (valid === 1'b1 && seq_on) begin
            if (have_prev) check(32'(char_out), 32'(prev_char + 10'h001));
            prev_char = char_out;
            have_prev = 1'b1;
        end
    end
    // Hang guard, generous for three self-test periods
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            miscompares++;
            report_and_stop;
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        srst = 1'b1; ref_clk = 1'b0; ref_run = 1'b1; host_run = 1'b0; seq_on = 1'b0;
        strobe = 1'b0; cfg_addr = '0; cfg_data = '0; have_prev = 1'b0; prev_char = '0;
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
        rnd = xs(32'hf013);
        phase_ns = 6'(24 + 8 * (rnd % 5));
        first_char = rnd[9:0];
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        apb(1'b0, tx_align_pkg::APB_STATE, 32'h0);
        check(32'(rd[8:0]), 32'h107);
        check(32'(irq), 32'h0);
        rnd = xs(rnd);
        apb(1'b0, 12'h00c, rnd);
        check({31'h0, er}, 32'h1);
        check(rd, 32'h0);
        $display("test reset_values done");
        host_run = 1'b1;
        check(32'(err), 32'h1);
        cfg(4'h1, 5'h01);
        wait_err(1'b0, 40);
        check(32'(err), 32'h0);
        cfg(4'h1, 5'h03);
        recenter(5'h07);
        check(32'(err), 32'h0);
        run_seq();
        count_rises(n);
        check(32'(in_tol(n, 400 / CHAR_CYC, 1)), 32'h1);
        $display("test ref_capture done");
        recenter(5'h06);
        check(32'(err), 32'h0);
        run_seq();
        $display("test host_capture done");
        host_run = 1'b0;
        wait_err(1'b1, 400);
        check(32'(err), 32'h1);
        check(32'(irq), 32'h0);
        apb(1'b1, tx_align_pkg::APB_MASK, 32'h1);
        repeat (2) @(posedge clk);
        check(32'(irq), 32'h1);
        host_run = 1'b1;
        repeat (300) @(posedge clk);
        check(32'(err), 32'h1);
        recenter(5'h06);
        check(32'(err), 32'h0);
        apb(1'b1, tx_align_pkg::APB_STATUS, 32'h1);
        repeat (2) @(posedge clk);
        check(32'(irq), 32'h0);
        $display("test buffer_fault done");
        cfg(4'h0, 5'h02);
        pulse_timing(w, p);
        pulse_timing(w, p);
        check(32'(in_tol(w, CHAR_CYC, 1)), 32'h1);
        check(32'(in_tol(p, 511 * CHAR_CYC, 2)), 32'h1);
        $display("test self_test done");
        cfg(4'h0, 5'h0f);
        count_rises(n);
        check(32'(in_tol(n, 800 / CHAR_CYC, 1)), 32'h1);
        recenter(5'h07);
        check(32'(err), 32'h0);
        ref_run = 1'b0;
        wait_err(1'b1, 300);
        check(32'(err), 32'h1);
        $display("test rate_and_ref_loss done");
        report_and_stop;
    end
endmodule // tx_parallel_input_phase_align_tb
`default_nettype wire
